/* include/pipr_defs.svh */
// Offsets, field positions, reset values and keys of the input pin remapper
`ifndef PIPR_DEFS_SVH
`define PIPR_DEFS_SVH

// Register family size; this block carries eight of the input registers
`define PIPR_NUM_IN_REGS 21
`define PIPR_NUM_OUT_REGS 16
`define PIPR_NUM_REGS 37

// Register addresses on the plain register port
`define PIPR_ADDR_W 8
`define PIPR_ADDR_IRQ1 8'h00
`define PIPR_ADDR_IRQ3_IRQ2 8'h01
`define PIPR_ADDR_IRQ4 8'h02
`define PIPR_ADDR_TMR3_TMR2 8'h03
`define PIPR_ADDR_TMR5_TMR4 8'h04
`define PIPR_ADDR_CAP2_CAP1 8'h07
`define PIPR_ADDR_CAP4_CAP3 8'h08
`define PIPR_ADDR_CAP6_CAP5 8'h09
`define PIPR_ADDR_OSC_CTRL 8'h20

// Field layout
`define PIPR_DATA_W 16
`define PIPR_SEL_W 6
`define PIPR_HI_LSB 8
`define PIPR_LO_LSB 0
`define PIPR_LOCK_BIT 6

// Reset values
`define PIPR_SEL_RESET 6'h3f
`define PIPR_LOCK_RESET 1'b0

// Unlock keys written to the low byte of the oscillator control register
`define PIPR_KEY1 8'h46
`define PIPR_KEY2 8'h57

// Highest valid pin number; pin count is one more
`define PIPR_PIN_LIMIT 43
`define PIPR_NUM_PINS 44

// Selector slots
`define PIPR_NUM_SEL 14
`define PIPR_SLOT_IRQ1 0
`define PIPR_SLOT_IRQ2 1
`define PIPR_SLOT_IRQ3 2
`define PIPR_SLOT_IRQ4 3
`define PIPR_SLOT_TMR2 4
`define PIPR_SLOT_TMR3 5
`define PIPR_SLOT_TMR4 6
`define PIPR_SLOT_TMR5 7
`define PIPR_SLOT_CAP1 8
`define PIPR_SLOT_CAP2 9
`define PIPR_SLOT_CAP3 10
`define PIPR_SLOT_CAP4 11
`define PIPR_SLOT_CAP5 12
`define PIPR_SLOT_CAP6 13

`endif

/* include/pipr_pkg.sv */
// Types shared by the input pin remapper files
package pipr_pkg;

  typedef enum logic [1:0] {
    UNLK_IDLE,
    UNLK_KEY1,
    UNLK_ARMED
  } pipr_unlock_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pipr_bus_req_s;

  typedef struct packed {
    logic [3:0] ext_irq;
    logic [3:0] timer_clk;
    logic [5:0] capture;
  } pipr_periph_in_s;

endpackage

/* logic/pipr_sel.sv */
// One selector: routes the named pin to a peripheral input
`timescale 1ns/1ps
module pipr_sel #(
  parameter int NUM_PINS = 44,
  parameter int SEL_W = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NUM_PINS-1:0] pins,
  input wire logic [SEL_W-1:0] sel,
  output logic route_out
);

  logic route_reg;
  logic route_next;

  always_comb
  begin
    route_next = 1'b0;
    // Out-of-range values leave the input unconnected, held low
    if (int'(sel) < NUM_PINS)
    begin
      route_next = pins[sel];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_reg <= 1'b0;
    end
    else
    begin
      route_reg <= route_next;
    end
  end

  assign route_out = route_reg;

endmodule

/* logic/pipr_top.sv */
// Input side of the peripheral pin remapper: selectors, lock and routing
//
// Notes on behaviour
// - Family has 37 route registers, 21 input and 16 output ones.
// - Route registers change only while the map write lock reads zero.
// - Each selector is six bits, at 13..8 or 5..0, naming a pin.
// - Unimplemented bits ignore writes and read as zero.
// - Implemented selector bits are read/write and reset to one.
// - Register 0 holds external interrupt 1 in its upper field only.
// - Register 1 holds interrupt 3 upper and interrupt 2 lower.
// - Register 2 holds only interrupt 4 in bits 5..0.
// - Register 3 routes timer 3 clock upper, timer 2 clock lower.
// - Register 4 routes timer 5 clock upper, timer 4 clock lower.
// - Register 7 routes capture 2 upper, capture 1 lower.
// - Register 8 routes capture 4 upper, capture 3 lower.
// - Register 9 routes capture 6 upper, capture 5 lower.
// - Lock bit changes only after keys 46h then 57h to the low byte.
// - With the session fuse set, a set lock cannot clear until reset.
// - Lock comes out of reset unlocked.
// - Selector values above 43 leave the input unconnected and low.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "pipr_defs.svh"
module pipr_top #(
  parameter int NUM_PINS = `PIPR_NUM_PINS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input pipr_pkg::pipr_bus_req_s bus_req,
  output logic [15:0] bus_rdata,
  input wire logic single_session_fuse,
  input wire logic [NUM_PINS-1:0] remappable_io_pin,
  output pipr_pkg::pipr_periph_in_s periph_in,
  output logic map_write_lock
);

  localparam int NSEL = `PIPR_NUM_SEL;
  localparam int SW = `PIPR_SEL_W;

  // Pin and fuse synchronisers; the first stage feeds only the second
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic fuse_meta_reg;
  logic fuse_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      fuse_meta_reg <= 1'b1;
      fuse_sync_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= remappable_io_pin;
      pin_sync_reg <= pin_meta_reg;
      fuse_meta_reg <= single_session_fuse;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // Bus decode
  logic osc_wr;
  logic [7:0] key_byte;
  logic lock_wdata;

  assign osc_wr = bus_req.wr && (bus_req.addr == `PIPR_ADDR_OSC_CTRL);
  assign key_byte = bus_req.wdata[7:0];
  assign lock_wdata = bus_req.wdata[`PIPR_LOCK_BIT];

  // Unlock sequence and lock bit
  pipr_pkg::pipr_unlock_e unlk_reg;
  pipr_pkg::pipr_unlock_e unlk_next;
  logic lock_reg;
  logic lock_next;

  always_comb
  begin
    unlk_next = unlk_reg;
    lock_next = lock_reg;
    case (unlk_reg)
      pipr_pkg::UNLK_IDLE:
      begin
        if (osc_wr && key_byte == `PIPR_KEY1)
        begin
          unlk_next = pipr_pkg::UNLK_KEY1;
        end
      end
      pipr_pkg::UNLK_KEY1:
      begin
        // Any other write breaks the sequence, a repeated first key restarts it; no other write may fall between the keys
        if (osc_wr && key_byte == `PIPR_KEY2)
        begin
          unlk_next = pipr_pkg::UNLK_ARMED;
        end
        else if (osc_wr && key_byte == `PIPR_KEY1)
        begin
          unlk_next = pipr_pkg::UNLK_KEY1;
        end
        else if (bus_req.wr)
        begin
          unlk_next = pipr_pkg::UNLK_IDLE;
        end
      end
      pipr_pkg::UNLK_ARMED:
      begin
        if (osc_wr)
        begin
          unlk_next = pipr_pkg::UNLK_IDLE;
          // A set lock under the session fuse stays set until reset
          if (lock_wdata || !(fuse_sync_reg && lock_reg))
          begin
            lock_next = lock_wdata;
          end
        end
        else if (bus_req.wr)
        begin
          unlk_next = pipr_pkg::UNLK_IDLE;
        end
      end
      default:
      begin
        unlk_next = pipr_pkg::UNLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unlk_reg <= pipr_pkg::UNLK_IDLE;
      lock_reg <= `PIPR_LOCK_RESET;
    end
    else
    begin
      unlk_reg <= unlk_next;
      lock_reg <= lock_next;
    end
  end

  // Selector storage, one six-bit field per peripheral input
  logic [SW-1:0] sel_reg [NSEL];
  logic [SW-1:0] sel_next [NSEL];
  logic [SW-1:0] wr_hi;
  logic [SW-1:0] wr_lo;
  logic sel_wr_ok;

  // Only the field bits are taken; bits 15..14 and 7..6 are dropped
  assign wr_hi = bus_req.wdata[`PIPR_HI_LSB +: SW];
  assign wr_lo = bus_req.wdata[`PIPR_LO_LSB +: SW];
  // Locked writes are accepted on the bus but change nothing
  assign sel_wr_ok = bus_req.wr && !lock_reg;

  always_comb
  begin
    for (int i = 0; i < NSEL; i++)
    begin
      sel_next[i] = sel_reg[i];
    end
    if (sel_wr_ok)
    begin
      // Eight of the family's input registers live here
      case (bus_req.addr)
        `PIPR_ADDR_IRQ1:
        begin
          sel_next[`PIPR_SLOT_IRQ1] = wr_hi;
        end
        `PIPR_ADDR_IRQ3_IRQ2:
        begin
          sel_next[`PIPR_SLOT_IRQ3] = wr_hi;
          sel_next[`PIPR_SLOT_IRQ2] = wr_lo;
        end
        `PIPR_ADDR_IRQ4:
        begin
          sel_next[`PIPR_SLOT_IRQ4] = wr_lo;
        end
        `PIPR_ADDR_TMR3_TMR2:
        begin
          sel_next[`PIPR_SLOT_TMR3] = wr_hi;
          sel_next[`PIPR_SLOT_TMR2] = wr_lo;
        end
        `PIPR_ADDR_TMR5_TMR4:
        begin
          sel_next[`PIPR_SLOT_TMR5] = wr_hi;
          sel_next[`PIPR_SLOT_TMR4] = wr_lo;
        end
        `PIPR_ADDR_CAP2_CAP1:
        begin
          sel_next[`PIPR_SLOT_CAP2] = wr_hi;
          sel_next[`PIPR_SLOT_CAP1] = wr_lo;
        end
        `PIPR_ADDR_CAP4_CAP3:
        begin
          sel_next[`PIPR_SLOT_CAP4] = wr_hi;
          sel_next[`PIPR_SLOT_CAP3] = wr_lo;
        end
        `PIPR_ADDR_CAP6_CAP5:
        begin
          sel_next[`PIPR_SLOT_CAP6] = wr_hi;
          sel_next[`PIPR_SLOT_CAP5] = wr_lo;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NSEL; i++)
      begin
        sel_reg[i] <= `PIPR_SEL_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NSEL; i++)
      begin
        sel_reg[i] <= sel_next[i];
      end
    end
  end

  // Read path: data stand in the cycle after the strobe only
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  function automatic logic [15:0] pack_pair(input logic [SW-1:0] hi,
                                            input logic [SW-1:0] lo);
    logic [15:0] v;
    v = '0;
    v[`PIPR_HI_LSB +: SW] = hi;
    v[`PIPR_LO_LSB +: SW] = lo;
    return v;
  endfunction

  always_comb
  begin
    rdata_next = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `PIPR_ADDR_IRQ1:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_IRQ1], '0);
        end
        `PIPR_ADDR_IRQ3_IRQ2:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_IRQ3],
                                 sel_reg[`PIPR_SLOT_IRQ2]);
        end
        `PIPR_ADDR_IRQ4:
        begin
          rdata_next = pack_pair('0, sel_reg[`PIPR_SLOT_IRQ4]);
        end
        `PIPR_ADDR_TMR3_TMR2:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_TMR3],
                                 sel_reg[`PIPR_SLOT_TMR2]);
        end
        `PIPR_ADDR_TMR5_TMR4:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_TMR5],
                                 sel_reg[`PIPR_SLOT_TMR4]);
        end
        `PIPR_ADDR_CAP2_CAP1:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_CAP2],
                                 sel_reg[`PIPR_SLOT_CAP1]);
        end
        `PIPR_ADDR_CAP4_CAP3:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_CAP4],
                                 sel_reg[`PIPR_SLOT_CAP3]);
        end
        `PIPR_ADDR_CAP6_CAP5:
        begin
          rdata_next = pack_pair(sel_reg[`PIPR_SLOT_CAP6],
                                 sel_reg[`PIPR_SLOT_CAP5]);
        end
        `PIPR_ADDR_OSC_CTRL:
        begin
          // Oscillator fields live elsewhere; only the lock shows here
          rdata_next[`PIPR_LOCK_BIT] = lock_reg;
        end
        default:
        begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Routing: one registered selector per peripheral input
  logic [NSEL-1:0] route_bits;

  genvar g;
  generate
    for (g = 0; g < NSEL; g++)
    begin : g_sel
      pipr_sel #(
        .NUM_PINS(NUM_PINS),
        .SEL_W(SW)
      ) u_sel (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pins(pin_sync_reg),
        .sel(sel_reg[g]),
        .route_out(route_bits[g])
      );
    end
  endgenerate

  // Slot order matches the struct: irq1..4, timer2..5, capture1..6
  always_comb
  begin
    periph_in.ext_irq = route_bits[`PIPR_SLOT_IRQ4:`PIPR_SLOT_IRQ1];
    periph_in.timer_clk = route_bits[`PIPR_SLOT_TMR5:`PIPR_SLOT_TMR2];
    periph_in.capture = route_bits[`PIPR_SLOT_CAP6:`PIPR_SLOT_CAP1];
  end

  assign bus_rdata = rdata_reg;
  assign map_write_lock = lock_reg;

endmodule

/* testbench/pipr_top_assertions.sv */
// Port-level checker for the input pin remapper
`timescale 1ns/1ps
module pipr_top_assertions #(
  parameter int NUM_PINS = 44
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input pipr_pkg::pipr_bus_req_s bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic single_session_fuse,
  input wire logic [NUM_PINS-1:0] remappable_io_pin,
  input pipr_pkg::pipr_periph_in_s periph_in,
  input wire logic map_write_lock
);
  // Set once any write to an address below 10h was seen since reset
  logic touched_reg;
  logic touched_next;

  always_comb
  begin
    touched_next = touched_reg | (bus_req.wr & (bus_req.addr < 8'h10));
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      touched_reg <= 1'b0;
    end
    else
    begin
      touched_reg <= touched_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_rdata_quiet: assert property (
    !$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside a read cycle");
  chk_pad_zero: assert property (
    $past(bus_req.rd && bus_req.addr != 8'h20)
    |-> bus_rdata[15:14] == 2'h0 && bus_rdata[7:6] == 2'h0)
    else $error("unimplemented bits read nonzero");
  chk_osc_read: assert property (
    $past(bus_req.rd && bus_req.addr == 8'h20)
    |-> bus_rdata == {9'h000, $past(map_write_lock), 6'h00})
    else $error("oscillator control read wrong");
  chk_lock_cause: assert property (
    $changed(map_write_lock) |-> $past(bus_req.wr)
    && $past(bus_req.addr) == 8'h20
    && $past(bus_req.wdata[6]) == map_write_lock)
    else $error("lock changed without a control write");
  chk_lock_oneway: assert property (
    map_write_lock && single_session_fuse
    && $past(single_session_fuse) && $past(single_session_fuse, 2)
    |=> map_write_lock)
    else $error("lock cleared in single session mode");
  chk_lock_unlocked: assert property (
    $rose(rst_n) |-> !map_write_lock)
    else $error("lock set after reset");
  chk_reset_idle: assert property (
    !touched_reg |-> periph_in == '0)
    else $error("reset selectors do not tie inputs low");
  chk_route_cause: assert property (
    $changed(periph_in)
    |-> $past(remappable_io_pin, 3) != $past(remappable_io_pin, 4)
    || $past(bus_req.wr) || $past(bus_req.wr, 2) || !$past(rst_n, 5))
    else $error("peripheral input changed without cause");
endmodule

bind pipr_top pipr_top_assertions #(.NUM_PINS(NUM_PINS)) u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .single_session_fuse(single_session_fuse),
  .remappable_io_pin(remappable_io_pin),
  .periph_in(periph_in),
  .map_write_lock(map_write_lock)
);

/* testbench/pipr_pin_model.sv */
// Far-side model of the remappable pins
`timescale 1ns/1ps
module pipr_pin_model (
  input wire logic ref_clk,
  input wire logic [43:0] level,
  output logic [43:0] pins
);
  // Pins move just after an edge, so the synchroniser timing is repeatable
  initial pins = '0;
  always @(posedge ref_clk) pins <= level;
endmodule

/* testbench/tb_pipr_top.sv */
// Self-checking bench for the input pin remapper
`timescale 1ns/1ps
module tb_pipr_top;
  logic ref_clk;
  logic rst_n;
  pipr_pkg::pipr_bus_req_s bus_req;
  logic [15:0] bus_rdata;
  logic single_session_fuse;
  logic [43:0] pin_level;
  logic [43:0] pins;
  pipr_pkg::pipr_periph_in_s periph_in;
  logic map_write_lock;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  // Address, reset value, value read after writing 16'hd5e5
  logic [39:0] rows [9] = '{
    {8'h00, 16'h3f00, 16'h1500}, {8'h01, 16'h3f3f, 16'h1525},
    {8'h02, 16'h003f, 16'h0025}, {8'h03, 16'h3f3f, 16'h1525},
    {8'h04, 16'h3f3f, 16'h1525}, {8'h07, 16'h3f3f, 16'h1525},
    {8'h08, 16'h3f3f, 16'h1525}, {8'h09, 16'h3f3f, 16'h1525},
    {8'h05, 16'h0000, 16'h0000}};

  pipr_top DUT (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .single_session_fuse(single_session_fuse),
    .remappable_io_pin(pins),
    .periph_in(periph_in),
    .map_write_lock(map_write_lock)
  );
  pipr_pin_model u_pins (.ref_clk(ref_clk), .level(pin_level), .pins(pins));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ceiling well above the some 170 cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk) bus_req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk) bus_req <= '0;
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge ref_clk) bus_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk) bus_req <= '0;
    #1 chk("read data", bus_rdata, exp);
  endtask

  task automatic set_lock(logic v);
    wr(8'h20, 16'h0046);
    wr(8'h20, 16'h0057);
    wr(8'h20, {9'h000, v, 6'h00});
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    single_session_fuse = 1'b0;
    pin_level = '1;
    do_reset();
    foreach (rows[i])
    begin
      rd(rows[i][39:32], rows[i][31:16]);
      wr(rows[i][39:32], 16'hd5e5);
      rd(rows[i][39:32], rows[i][15:0]);
    end
    $display("Register table test done");
    wr(8'h01, 16'h052b);
    wr(8'h02, 16'h002c);
    pin_level <= 44'h000_0000_0020;
    repeat (5) @(posedge ref_clk);
    #1 chk("routes", {2'h0, periph_in}, 16'h1000);
    pin_level <= ~44'h000_0000_0020;
    repeat (5) @(posedge ref_clk);
    #1 chk("routes", {2'h0, periph_in}, 16'h0fff);
    // Route follows the new selector from the edge after the write
    wr(8'h00, 16'h0500);
    #1 chk("routes", {2'h0, periph_in}, 16'h0fff);
    @(posedge ref_clk);
    #1 chk("routes", {2'h0, periph_in}, 16'h0bff);
    $display("Routing test done");
    set_lock(1'b1);
    chk("lock", {15'h0000, map_write_lock}, 16'h0001);
    wr(8'h03, 16'h0000);
    rd(8'h03, 16'h1525);
    rd(8'h20, 16'h0040);
    set_lock(1'b0);
    chk("lock", {15'h0000, map_write_lock}, 16'h0000);
    // A foreign write between the keys must abort the sequence
    wr(8'h20, 16'h0046);
    wr(8'h01, 16'h0000);
    wr(8'h20, 16'h0057);
    wr(8'h20, 16'h0040);
    rd(8'h20, 16'h0000);
    rd(8'h01, 16'h0000);
    // A repeated first key restarts the sequence instead of aborting it
    wr(8'h20, 16'h0046);
    wr(8'h20, 16'h0046);
    wr(8'h20, 16'h0057);
    wr(8'h20, 16'h0040);
    rd(8'h20, 16'h0040);
    set_lock(1'b0);
    single_session_fuse <= 1'b1;
    set_lock(1'b1);
    set_lock(1'b0);
    chk("lock", {15'h0000, map_write_lock}, 16'h0001);
    $display("Lock test done");
    do_reset();
    @(posedge ref_clk);
    #1 chk("lock", {15'h0000, map_write_lock}, 16'h0000);
    rd(8'h03, 16'h3f3f);
    $display("Second reset test done");
    wrap_up();
  end
endmodule
